/* verilog/apms_pkg.sv */
// Constants, field layouts and state types of the converter power-mode sequencer.
// Assumes a 100 MHz system clock; all times below are converted to cycles of it.

package apms_pkg;

  // ---------------------------------------------------------------
  // Clock and times
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int T_FAST_NS     = 1000;      // Fast wake
  localparam int T_REF_NS      = 30000;     // Reference only, no cap to charge
  localparam int T_COLD_NS     = 182000;    // Reference plus cap charge
  localparam int T_CONV_NS     = 2300;      // Conversion
  localparam int T_LONG_PD_NS  = 1000000;   // Full power-down treated as long
  localparam int NS_PER_US     = 1000;
  // Least times round up to whole cycles
  localparam int FAST_CYC      = (T_FAST_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int REF_CYC       = (T_REF_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int COLD_CYC      = (T_COLD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int CONV_CYC      = (T_CONV_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int LONG_PD_CYC   = (T_LONG_PD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int TMR_W         = 17;

  // ---------------------------------------------------------------
  // Control word and serial frame
  // ---------------------------------------------------------------
  localparam int CTRL_W        = 10;
  localparam int PD_HI_BIT     = 8;
  localparam int PD_LO_BIT     = 7;
  localparam int EXT_REF_BIT   = 0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam int RESULT_W      = 10;
  localparam int FRAME_W       = 16;
  localparam logic [3:0] RD_LAST_EDGE = 4'hB;   // Output released on this edge
  localparam logic [3:0] WR_UPD_EDGE  = 4'hD;   // Control word taken on this edge
  localparam logic [1:0] MODE_UP   = 2'h3;
  localparam logic [1:0] MODE_DOWN = 2'h0;
  localparam logic [1:0] MODE_PART = 2'h1;
  localparam logic [1:0] MODE_FULL = 2'h2;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W        = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] RESULT_OFS = 8'h08;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {PS_OFF, PS_FULL_PD, PS_PART_PD, PS_WAKE, PS_READY, PS_CONV} apms_pwr_type;

endpackage : apms_pkg

/* verilog/apms_sequencer.sv */
// Power-mode and conversion sequencer with framed serial port and register slave.
// Assumes adc_code comes from the converter core on clk; all pins are asynchronous.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

module apms_sequencer
  import apms_pkg::*;
#(
  parameter int COLD_WAKE_CYC = COLD_CYC,
  parameter int LONG_PD_LIMIT = LONG_PD_CYC
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // Converter pins
  input  wire logic                convert_strobe_n,
  input  wire logic                sclk,
  input  wire logic                read_frame_sync,
  input  wire logic                write_frame_sync,
  input  wire logic                din,
  output logic                     dout,
  output logic                     dout_en_n,
  // Converter core
  input  wire logic [RESULT_W-1:0] adc_code,
  output logic                     main_power_on,
  output logic                     ref_power_on,
  output logic                     sample_hold,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam logic [TMR_W-1:0] FAST_LD = TMR_W'(FAST_CYC - 1);
  localparam logic [TMR_W-1:0] REF_LD  = TMR_W'(REF_CYC - 1);
  localparam logic [TMR_W-1:0] COLD_LD = TMR_W'(COLD_WAKE_CYC - 1);
  localparam logic [TMR_W-1:0] CONV_LD = TMR_W'(CONV_CYC - 1);
  localparam logic [TMR_W-1:0] LONG_PD = TMR_W'(LONG_PD_LIMIT);

  typedef struct packed {
    logic [2:0]          cs_sync;
    logic [2:0]          sck_sync;
    logic [2:0]          rfs_sync;
    logic [2:0]          tfs_sync;
    logic [1:0]          din_sync;
    apms_pwr_type        pwr;
    logic [TMR_W-1:0]    timer;
    logic [TMR_W-1:0]    pd_time;
    logic                cold;
    logic                conv_pend;
    logic [CTRL_W-1:0]   ctrl;
    logic [RESULT_W-1:0] result;
    logic [FRAME_W-1:0]  out_shift;
    logic                load_pend;
    logic                rd_arm;
    logic [3:0]          rd_cnt;
    logic                dout;
    logic                dout_en_n;
    logic                wr_arm;
    logic [3:0]          wr_rise;
    logic [3:0]          wr_fall;
    logic [CTRL_W-1:0]   wr_bits;
    logic                main_on;
    logic                ref_on;
    logic                hold;
    logic                awready;
    logic                wready;
    logic                aw_got;
    logic                w_got;
    logic [ADDR_W-1:0]   aw_addr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } apms_state_type;

  apms_state_type st;
  apms_state_type next_st;

  // Wake time from the state being left
  function automatic logic [TMR_W-1:0] wake_load(input apms_pwr_type from, input logic [1:0] mode,
                                                 input logic ext, input logic cold);
    if (ext || from == PS_PART_PD)
      wake_load = FAST_LD;
    else if (cold && mode == MODE_PART)
      wake_load = REF_LD;
    else if (cold)
      wake_load = COLD_LD;
    else
      wake_load = FAST_LD;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic                cs_level;
  logic                cs_rise;
  logic                cs_fall;
  logic                sck_rise;
  logic                sck_fall;
  logic                rfs_rise;
  logic                tfs_fall;
  logic [1:0]          mode;
  logic                ext_ref;
  logic                ctrl_wr;
  logic [CTRL_W-1:0]   ctrl_new;
  logic                conv_end;
  logic [31:0]         rd_word;
  logic                rd_hit;

  always_comb begin
    next_st = st;
    // Two flops ahead of any edge detection; third stage only delays
    next_st.cs_sync  = {st.cs_sync[1:0], convert_strobe_n};
    next_st.sck_sync = {st.sck_sync[1:0], sclk};
    next_st.rfs_sync = {st.rfs_sync[1:0], read_frame_sync};
    next_st.tfs_sync = {st.tfs_sync[1:0], write_frame_sync};
    next_st.din_sync = {st.din_sync[0], din};
    cs_level = st.cs_sync[1];
    cs_rise  = st.cs_sync[1] & ~st.cs_sync[2];
    cs_fall  = ~st.cs_sync[1] & st.cs_sync[2];
    sck_rise = st.sck_sync[1] & ~st.sck_sync[2];
    sck_fall = ~st.sck_sync[1] & st.sck_sync[2];
    rfs_rise = st.rfs_sync[1] & ~st.rfs_sync[2];
    tfs_fall = ~st.tfs_sync[1] & st.tfs_sync[2];
    mode     = {st.ctrl[PD_HI_BIT], st.ctrl[PD_LO_BIT]};
    ext_ref  = st.ctrl[EXT_REF_BIT];
    ctrl_wr  = 1'b0;
    ctrl_new = st.ctrl;
    conv_end = 1'b0;
    rd_word  = 32'h0000_0000;
    rd_hit   = 1'b1;

    // Serial read: counter armed by sync rise, works in every power state
    if (rfs_rise) begin
      next_st.rd_arm    = 1'b1;
      next_st.rd_cnt    = 4'h0;
      next_st.dout_en_n = 1'b1;
    end else if (st.rd_arm && sck_rise) begin
      if (st.rd_cnt == RD_LAST_EDGE - 4'h1) begin
        next_st.dout_en_n = 1'b1;
        next_st.rd_arm    = 1'b0;
        next_st.rd_cnt    = 4'h0;
      end else begin
        next_st.dout      = st.out_shift[4'(FRAME_W - 1) - st.rd_cnt];
        next_st.dout_en_n = 1'b0;
        next_st.rd_cnt    = st.rd_cnt + 4'h1;
      end
    end

    // Serial write: bits on falling edges, word taken on a rising edge count
    if (tfs_fall) begin
      next_st.wr_arm  = 1'b1;
      next_st.wr_rise = 4'h0;
      next_st.wr_fall = 4'h0;
      next_st.wr_bits = CTRL_RST;
    end else if (st.wr_arm) begin
      if (sck_fall && st.wr_fall < 4'(CTRL_W)) begin
        next_st.wr_bits[4'(CTRL_W - 1) - st.wr_fall] = st.din_sync[1];
        next_st.wr_fall = st.wr_fall + 4'h1;
      end
      if (sck_rise) begin
        next_st.wr_rise = st.wr_rise + 4'h1;
        if (st.wr_rise == WR_UPD_EDGE - 4'h1) begin
          ctrl_wr        = 1'b1;
          ctrl_new       = st.wr_bits;
          next_st.wr_arm = 1'b0;
        end
      end
    end

    // AXI write channels, taken in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      if (st.aw_addr == CTRL_OFS) begin
        // A serial update in the same cycle takes precedence
        if (!ctrl_wr) begin
          ctrl_wr = 1'b1;
          if (st.wstrb[0])
            ctrl_new[7:0] = st.wdata[7:0];
          if (st.wstrb[1])
            ctrl_new[CTRL_W-1:8] = st.wdata[CTRL_W-1:8];
        end
      end else if (st.aw_addr != STATUS_OFS && st.aw_addr != RESULT_OFS) begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;

    // AXI read
    unique case (s_axi_araddr)
      CTRL_OFS:   rd_word = 32'(st.ctrl);
      STATUS_OFS: rd_word = 32'({st.cold, st.load_pend, ~st.dout_en_n, st.conv_pend, st.pwr});
      RESULT_OFS: rd_word = 32'(st.result);
      default:    rd_hit  = 1'b0;
    endcase
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    next_st.arready = !next_st.rvalid;

    if (ctrl_wr)
      next_st.ctrl = ctrl_new;

    // Long full power-down lets the reference cap drain
    if (st.pwr == PS_FULL_PD && !ext_ref) begin
      if (st.pd_time >= LONG_PD)
        next_st.cold = 1'b1;
      else
        next_st.pd_time = st.pd_time + TMR_W'(1);
    end else begin
      next_st.pd_time = '0;
    end

    // Power and conversion sequencing; timer counts system clocks
    if (st.timer != '0)
      next_st.timer = st.timer - TMR_W'(1);
    unique case (st.pwr)
      PS_OFF: begin
        // Low-current until both power bits are written set
        if (mode == MODE_UP) begin
          next_st.pwr   = PS_WAKE;
          next_st.timer = wake_load(st.pwr, mode, ext_ref, st.cold);
        end
      end
      PS_FULL_PD, PS_PART_PD: begin
        if (mode == MODE_UP || ((mode == MODE_FULL || mode == MODE_PART) && cs_rise)) begin
          next_st.pwr   = PS_WAKE;
          next_st.timer = wake_load(st.pwr, mode, ext_ref, st.cold);
        end else if (mode == MODE_DOWN) begin
          next_st.pwr = PS_FULL_PD;
        end
      end
      PS_WAKE: begin
        if (cs_fall)
          next_st.conv_pend = 1'b1;
        if (mode == MODE_DOWN) begin
          next_st.pwr       = PS_FULL_PD;
          next_st.conv_pend = 1'b0;
        end else if (st.timer == '0) begin
          next_st.cold = 1'b0;
          if (st.conv_pend || cs_fall) begin
            next_st.pwr       = PS_CONV;
            next_st.timer     = CONV_LD;
            next_st.conv_pend = 1'b0;
          end else begin
            next_st.pwr = PS_READY;
          end
        end
      end
      PS_READY: begin
        if (mode == MODE_DOWN) begin
          next_st.pwr = PS_FULL_PD;
        end else if (cs_fall) begin
          next_st.pwr   = PS_CONV;
          next_st.timer = CONV_LD;
        end
      end
      PS_CONV: begin
        if (st.timer == '0) begin
          conv_end       = 1'b1;
          next_st.result = adc_code;
          // In the full and partial power-down settings the strobe level at this moment picks the mode
          if (mode == MODE_UP)
            next_st.pwr = PS_READY;
          else if (mode == MODE_DOWN)
            next_st.pwr = PS_FULL_PD;
          else if (cs_level)
            next_st.pwr = PS_READY;
          else if (mode == MODE_FULL)
            next_st.pwr = PS_FULL_PD;
          else
            next_st.pwr = PS_PART_PD;
        end
      end
      default: next_st.pwr = PS_OFF;
    endcase

    // Result reaches the shift register only between reads
    if (conv_end && !st.dout_en_n) begin
      next_st.load_pend = 1'b1;
    end else if (conv_end) begin
      next_st.out_shift = {adc_code, {(FRAME_W - RESULT_W){1'b0}}};
    end else if (st.load_pend && next_st.dout_en_n) begin
      next_st.load_pend = 1'b0;
      next_st.out_shift = {st.result, {(FRAME_W - RESULT_W){1'b0}}};
    end

    // Analog enables follow the power state
    next_st.main_on = next_st.pwr == PS_WAKE || next_st.pwr == PS_READY || next_st.pwr == PS_CONV;
    next_st.ref_on  = !next_st.ctrl[EXT_REF_BIT] && (next_st.main_on || next_st.pwr == PS_PART_PD);
    next_st.hold    = next_st.pwr == PS_CONV;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Strobe and write-sync stages reset released high so no false edge is seen after reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st           <= '0;
      st.pwr       <= PS_OFF;
      st.ctrl      <= CTRL_RST;
      st.cold      <= 1'b1;
      st.dout_en_n <= 1'b1;
      st.cs_sync   <= 3'h7;
      st.tfs_sync  <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign dout          = st.dout;
  assign dout_en_n     = st.dout_en_n;
  assign main_power_on = st.main_on;
  assign ref_power_on  = st.ref_on;
  assign sample_hold   = st.hold;
  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rvalid  = st.rvalid;

endmodule // apms_sequencer

/* testbench/apms_sequencer_props.sv */
// Port-level properties of the power-mode sequencer.
// Assumes it is bound onto apms_sequencer running on a 100 MHz clk.
`timescale 1ns/1ps

module apms_sequencer_props
  import apms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Watched pins
  input wire logic convert_strobe_n,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_en_n,
  input wire logic main_power_on,
  input wire logic sample_hold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ------------------------------
  // Run-length counters
  // ------------------------------
  logic [15:0] hold_cnt;
  logic [15:0] en_cnt;
  // Lengths of a hold and of an open read, far too long for a repetition
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hold_cnt <= 16'h0000;
      en_cnt   <= 16'h0000;
    end else begin
      hold_cnt <= sample_hold ? hold_cnt + 16'h0001 : 16'h0000;
      en_cnt   <= !dout_en_n ? en_cnt + 16'h0001 : 16'h0000;
    end
  end
  // Reset itself is watched, so this one has no disable
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> dout_en_n && !main_power_on && !sample_hold)
    else $error("outputs active after reset");
  a_conv_len: assert property ($fell(sample_hold) |-> hold_cnt == 16'(CONV_CYC))
    else $error("conversion length wrong");
  a_conv_start: assert property ($fell(convert_strobe_n) && main_power_on && !sample_hold |-> ##[1:120] sample_hold)
    else $error("conversion did not start");
  a_hold_power: assert property (sample_hold |-> main_power_on)
    else $error("hold while unpowered");
  a_mode1_up: assert property ($fell(sample_hold) && convert_strobe_n && $past(convert_strobe_n, 5) |-> main_power_on[*3])
    else $error("powered down with strobe high");
  a_en_on_sclk: assert property ($fell(dout_en_n) |-> $past(sclk, 2))
    else $error("output enabled without clock edge");
  a_dout_step: assert property ($changed(dout) && !dout_en_n && !$past(dout_en_n) |-> $past(sclk, 2))
    else $error("data moved without clock edge");
  a_en_len: assert property ($rose(dout_en_n) |-> en_cnt >= 16'h007C && en_cnt <= 16'h007E)
    else $error("read window not ten clocks");
endmodule // apms_sequencer_props

bind apms_sequencer apms_sequencer_props u_props (.clk(clk), .rstn(rstn), .convert_strobe_n(convert_strobe_n),
  .sclk(sclk), .dout(dout), .dout_en_n(dout_en_n), .main_power_on(main_power_on), .sample_hold(sample_hold));

/* testbench/apms_host.sv */
// Host serial port model: framed 16-bit full-duplex transfers.
// Assumes the bench calls xfer; its clock is free of the system clock.
`timescale 1ns/1ps

module apms_host (
  // Serial pins towards the block
  output logic        sclk,
  output logic        read_frame_sync,
  output logic        write_frame_sync,
  output logic        din,
  input  wire logic   dout,
  input  wire logic   dout_en_n,
  // Captured word
  output logic [15:0] rd_word,
  output logic        rd_done
);
  // Idle lines; the clock stands still between frames
  initial begin
    sclk             = 1'b0;
    read_frame_sync  = 1'b0;
    write_frame_sync = 1'b1;
    din              = 1'b0;
    rd_done          = 1'b0;
  end
  // ------------------------------
  // One 16-bit exchange, MSB first
  // ------------------------------
  task automatic xfer(input logic [15:0] w);
    rd_done          = 1'b0;
    read_frame_sync  = 1'b1;
    write_frame_sync = 1'b0;
    #100;
    for (int k = 15; k >= 0; k--) begin
      sclk = 1'b1;
      #31;
      din = w[k];
      #31.5;
      rd_word[k] = dout_en_n ? ~dout : dout;   // Released line shows the inverse, so a late bit is caught
      sclk       = 1'b0;
      #62.5;
    end
    read_frame_sync  = 1'b0;
    write_frame_sync = 1'b1;
    din              = ~din;    // No stale bit on a released line
    rd_done          = 1'b1;
    #200;                       // Gap before any strobe fall
  endtask
endmodule // apms_host

/* testbench/test_apms_sequencer.sv */
// Self-checking bench for the power-mode sequencer.
// Assumes apms_host as serial partner and the bound property checker.
`timescale 1ns/1ps

module test_apms_sequencer
  import apms_pkg::*;
  ;
  // ------------------------------
  // Signals and result notes
  // ------------------------------
  localparam logic [13:0] MODES [6] = '{{10'h181, 1'b0, 3'h4}, {10'h101, 1'b1, 3'h4}, {10'h101, 1'b0, 3'h1},
                                        {10'h081, 1'b1, 3'h4}, {10'h081, 1'b0, 3'h2}, {10'h001, 1'b0, 3'h1}};
  logic        clk, rstn, convert_strobe_n, sclk, read_frame_sync, write_frame_sync, din, dout, dout_en_n;
  logic        main_power_on, ref_power_on, sample_hold, host_done, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, exp_b[$];
  logic [9:0]  adc_code, code, kept, exp_s[$];
  logic [15:0] rd_word;
  logic [33:0] exp_r[$];
  int          n_errors, checked;

  apms_sequencer #(.COLD_WAKE_CYC(300), .LONG_PD_LIMIT(500)) u_apms_sequencer (.clk, .rstn, .convert_strobe_n, .sclk,
    .read_frame_sync, .write_frame_sync, .din, .dout, .dout_en_n, .adc_code, .main_power_on, .ref_power_on, .sample_hold,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  apms_host u_host (.sclk, .read_frame_sync, .write_frame_sync, .din, .dout, .dout_en_n, .rd_word,
    .rd_done(host_done));

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic strobe(input logic v);
    @(posedge clk);
    convert_strobe_n <= v;
  endtask
  // Fresh converter code from the xorshift stream
  task automatic new_code;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    code = seed[9:0];
    @(posedge clk);
    adc_code <= code;
  endtask
  task automatic sread(input logic [15:0] w, input logic [9:0] e);
    exp_s.push_back(e);
    u_host.xfer(w);
  endtask
  // ------------------------------
  // Bus master; a wait that runs out ends the run
  // ------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int i;
    exp_b.push_back(e);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 100) begin
      n_errors++;
      close_out;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    int i;
    exp_r.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 100) begin
      n_errors++;
      close_out;
    end
  endtask
  // Each answer is matched against the oldest note
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) check("bresp", 34'(s_axi_bresp), 34'(exp_b.pop_front()));
    if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
  end
  always @(posedge host_done) check("dout word", 34'(rd_word[15:6]), 34'(exp_s.pop_front()));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {rstn, convert_strobe_n, adc_code, seed, n_errors, checked} = {2'h1, 10'h000, 32'h00000029, 64'h0};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    cyc(10);
    rstn <= 1'b1;
    cyc(5);
    // A cold part ignores the strobe until powered up
    strobe(1'b0);
    cyc(50);
    strobe(1'b1);
    cyc(300);
    axi_rd(STATUS_OFS, {RESP_OKAY, 32'h00000040});
    axi_rd(8'hFC, {RESP_SLVERR, 32'h00000000});
    axi_wr(8'hFC, 32'h00000000, RESP_SLVERR);
    sread(16'h6040, 10'h000);                      // Shift register still cleared
    cyc(150);                                      // Settle after power-up write
    axi_rd(CTRL_OFS, {RESP_OKAY, 32'h00000181});
    axi_rd(STATUS_OFS, {RESP_OKAY, 32'h00000004});
    // Fast sampling: strobe back high before the end
    new_code;
    strobe(1'b0);
    cyc(50);
    strobe(1'b1);
    cyc(250);
    sread(16'h6040, code);
    exp_s.push_back(code);
    new_code;
    strobe(1'b0);
    cyc(50);
    strobe(1'b1);
    cyc(100);
    u_host.xfer(16'h6040);                         // Read overlaps the end
    sread(16'h6040, code);
    // Every power setting; both strobe levels at the end for the full and partial power-down settings
    foreach (MODES[m]) begin
      strobe(1'b1);                                // Wakes a powered-down part
      cyc(150);
      axi_wr(CTRL_OFS, 32'(MODES[m][13:4]), RESP_OKAY);
      new_code;
      cyc(5);
      strobe(1'b0);
      cyc(100);
      strobe(MODES[m][3]);                         // Level for the end set within conversion time
      cyc(200);
      axi_rd(STATUS_OFS, {RESP_OKAY, 29'h0, MODES[m][2:0]});
      if (m < 5) begin
        axi_rd(RESULT_OFS, {RESP_OKAY, 22'h0, code});
        kept = code;
      end
    end
    sread(16'h0040, kept);                         // Last converted code
    axi_rd(STATUS_OFS, {RESP_OKAY, 32'h00000001});
    // Strobe falls before wake ends: conversion follows the wake
    axi_wr(CTRL_OFS, 32'h00000101, RESP_OKAY);
    new_code;
    strobe(1'b1);
    cyc(20);
    strobe(1'b0);
    cyc(400);
    axi_rd(RESULT_OFS, {RESP_OKAY, 22'h0, code});
    axi_rd(STATUS_OFS, {RESP_OKAY, 32'h00000001});
    // Internal reference follows the core and drains in a long full power-down
    axi_wr(CTRL_OFS, 32'h00000180, RESP_OKAY);
    cyc(150);
    check("ref on", 34'(ref_power_on), 34'h1);
    axi_wr(CTRL_OFS, 32'h00000000, RESP_OKAY);
    cyc(600);
    check("ref off", 34'(ref_power_on), 34'h0);
    axi_rd(STATUS_OFS, {RESP_OKAY, 32'h00000041});
    // Drained cap gives the long wake
    axi_wr(CTRL_OFS, 32'h00000180, RESP_OKAY);
    cyc(150);
    axi_rd(STATUS_OFS, {RESP_OKAY, 32'h00000043});
    cyc(200);
    axi_rd(STATUS_OFS, {RESP_OKAY, 32'h00000004});
    close_out;
  end
endmodule // test_apms_sequencer
